// ---- hdl/rstseq_pkg.sv ----
// Constants for the reset sequencer: timing counts, configuration bits, flag bits.
// Assumes a 125 MHz CPU clock where one half-clock unit is half a period.
package rstseq_pkg;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int HALF_CLOCK_UNIT_PS = CLK_PERIOD_PS / 2;
  // Times in half-clock units, as the sequence defines them
  localparam int SEQ_LEN_HCU = 1024;
  localparam int SAMPLE_DLY_HCU = 8;
  localparam int MIN_LOW_HCU = 4;
  localparam int ENTRY_HCU = 16;
  // Cycles a pin edge spends in the two-flop synchroniser
  localparam int SYNC_LAT_CYC = 2;
  // Cycle counts derived from the rate (two units per clock)
  localparam int SEQ_LEN_CYC = (SEQ_LEN_HCU * HALF_CLOCK_UNIT_PS) / CLK_PERIOD_PS;
  localparam int SAMPLE_DLY_CYC = (SAMPLE_DLY_HCU * HALF_CLOCK_UNIT_PS) / CLK_PERIOD_PS;
  localparam int MIN_LOW_CYC =
    (MIN_LOW_HCU * HALF_CLOCK_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ENTRY_CYC = (ENTRY_HCU * HALF_CLOCK_UNIT_PS) / CLK_PERIOD_PS;
  localparam int CNT_W = 10;
  // System configuration register bits
  localparam int CFG_BIDIR_BIT = 3;
  localparam int CFG_PWD_PULLUP_BIT = 4;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Reset flag register bits
  localparam int FLG_LONG_HW = 1;
  localparam int FLG_SHORT_HW = 2;
  localparam int FLG_SW = 3;
  localparam int FLG_WDT = 4;
  localparam logic [4:0] FLG_RESET = 5'h00;
  // Configuration port latching
  localparam int P0_HI = 12;
  localparam int P0_LO = 8;
  localparam logic [5:0] P0_FORCED = 6'h3f;
  localparam logic [15:0] P0_RESET = 16'h0000;
  // APB map
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_P0 = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_BUSWAIT = 3'b001,
    ST_ENTRY = 3'b010,
    ST_SEQ = 3'b011,
    ST_SAMPLE = 3'b100,
    ST_INIT = 3'b101,
    ST_WATCH = 3'b110
  } rstseq_state_e;

  typedef enum logic [1:0] {
    SRC_HW = 2'b00,
    SRC_SW = 2'b01,
    SRC_WDT = 2'b10
  } rstseq_src_e;
endpackage : rstseq_pkg

// ---- hdl/rstseq_top.sv ----
// Synchronous reset sequencer: software, watchdog and warm hardware resets.
// Assumes pins arrive asynchronous; CPU strobes are single-cycle pulses on clk.
// Operation
// - Software reset instruction starts internal sequence
// - Relatch port bits 12..8, force 7..2 high
// - Software reset always synchronous
// - Software bidir drives reset pin only if powerdown high
// - Watchdog overflow triggers reset sequence
// - Watchdog completes non-ready or ready-low bus cycle
// - Watchdog aborts bus cycle when ready high
// - Watchdog reset synchronous, bidir gated by powerdown
// - Reset out low until end-of-init completes
// - Bidir enable bit 3, writable before end-of-init
// - Bidir pull-down active during whole internal sequence
// - Hardware short bidir: sample 8 units, maybe long
// - Soft/watchdog bidir: low 4 units means hardware
// - Powerdown low releases pin, sequence still completes
// - Every reset sequence clears bidir enable
// - Hardware flag masks earlier software/watchdog flag
// - Powerdown pull-up enabled at sequence end if configured
// - Powerdown pull-down on while reset pin low
// - Powerdown low with reset low: asynchronous reset
// - Warm reset needs reset pin low 4 units
// - Sequence 1024 units, sample 8 units later
//
// Local design decisions: the register offsets and the APB interface to the registers.
module rstseq_top
  import rstseq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [3:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU events
  input wire logic soft_reset_instr,
  input wire logic end_of_init_instr,
  input wire logic wdt_overflow,
  // External bus cycle state
  input wire logic bus_cycle_active,
  input wire logic bus_uses_ready,
  input wire logic bus_waits_done,
  input wire logic ready_n,
  output logic bus_abort,
  // Pins
  input wire logic filtered_reset_in,
  input wire logic powerdown_reset_pin,
  input wire logic [15:0] config_port_zero,
  output logic reset_in_pin_o,
  output logic reset_in_pin_oe,
  output logic reset_out_pin,
  output logic pd_pullup_en,
  output logic pd_pulldown_en,
  // Core reset and latched configuration
  output logic core_reset,
  output logic async_reset_req,
  output logic [15:0] port_cfg
);
  rstseq_state_e state, next_state;
  rstseq_src_e src, next_src;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [15:0] cfg, next_cfg;
  logic [4:0] flags, next_flags;
  logic [15:0] p0_lat, next_p0_lat;
  logic initd, next_initd;
  logic pull, next_pull;
  logic rout, next_rout;
  logic pdu, next_pdu;
  logic pdd, next_pdd;
  logic abort_q, next_abort_q;
  logic areq, next_areq;
  logic [31:0] rdata, next_rdata;
  logic rf_s1, rf_s2, pd_s1, pd_s2;
  logic [15:0] p0_s1, p0_s2;
  logic wr, rd, sw_seq;

  // Pins pass two flops; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rf_s1 <= 1'b1;
      rf_s2 <= 1'b1;
      pd_s1 <= 1'b1;
      pd_s2 <= 1'b1;
      p0_s1 <= P0_RESET;
      p0_s2 <= P0_RESET;
    end
    else
    begin
      rf_s1 <= filtered_reset_in;
      rf_s2 <= rf_s1;
      pd_s1 <= powerdown_reset_pin;
      pd_s2 <= pd_s1;
      p0_s1 <= config_port_zero;
      p0_s2 <= p0_s1;
    end
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  // Our own pull during a soft/watchdog sequence must not look like a hardware reset
  assign sw_seq = (src != SRC_HW) && (state == ST_BUSWAIT || state == ST_ENTRY
    || state == ST_SEQ);

  always_comb
  begin
    next_state = state;
    next_src = src;
    next_cnt = cnt;
    next_cfg = cfg;
    next_flags = flags;
    next_p0_lat = p0_lat;
    next_initd = initd;
    next_pull = pull;
    next_rout = rout;
    next_pdu = pdu;
    next_abort_q = 1'b0;
    next_areq = areq;
    next_rdata = rdata;
    next_pdd = !rf_s2;
    if (!rf_s2 && !pd_s2 && !sw_seq)
      next_areq = 1'b1;
    if (wr && paddr == ADDR_CFG && !initd)
      next_cfg = pwdata[15:0];
    case (state)
      ST_RUN:
      begin
        if (!rf_s2)
        begin
          next_src = SRC_HW;
          next_cnt = CNT_W'(1);
          next_state = ST_ENTRY;
        end
        else if (soft_reset_instr)
        begin
          next_src = SRC_SW;
          next_cnt = '0;
          next_state = ST_ENTRY;
        end
        else if (wdt_overflow)
        begin
          next_src = SRC_WDT;
          next_cnt = '0;
          next_state = ST_BUSWAIT;
        end
      end
      ST_BUSWAIT:
      begin
        // Ready-driven cycle that reads high at the wait end is cut short
        if (!bus_cycle_active || (bus_uses_ready && bus_waits_done && !ready_n))
          next_state = ST_ENTRY;
        else if (bus_uses_ready && bus_waits_done && ready_n)
        begin
          next_abort_q = 1'b1;
          next_state = ST_ENTRY;
        end
      end
      ST_ENTRY:
      begin
        // A glitch below the minimum width returns to RUN or INIT with rout, initd and cfg untouched; core_reset is high for one cycle
        if (src == SRC_HW && rf_s2 && cnt < CNT_W'(MIN_LOW_CYC))
          next_state = initd ? ST_RUN : ST_INIT;
        else
        begin
          next_rout = 1'b0;
          next_initd = 1'b0;
          if (src != SRC_HW || cnt >= CNT_W'(ENTRY_CYC))
          begin
            next_cnt = '0;
            next_pdu = 1'b0;
            next_pull = cfg[CFG_BIDIR_BIT] && (src == SRC_HW || pd_s2);
            next_state = ST_SEQ;
          end
          else
            next_cnt = cnt + CNT_W'(1);
        end
      end
      ST_SEQ:
      begin
        if (!pd_s2 && src != SRC_HW)
          next_pull = 1'b0;
        if (cnt == CNT_W'(SEQ_LEN_CYC - 1))
        begin
          next_cnt = '0;
          next_pull = 1'b0;
          next_pdu = cfg[CFG_PWD_PULLUP_BIT];
          next_cfg[CFG_BIDIR_BIT] = 1'b0;
          if (src == SRC_HW)
            next_state = ST_SAMPLE;
          else
          begin
            // Soft/watchdog: relatch only the config field 12..8
            next_p0_lat[P0_HI:P0_LO] = p0_s2[P0_HI:P0_LO];
            next_p0_lat[7:2] = P0_FORCED;
            next_flags = FLG_RESET;
            next_flags[FLG_SW] = 1'b1;
            next_flags[FLG_WDT] = (src == SRC_WDT);
            next_state = cfg[CFG_BIDIR_BIT] ? ST_WATCH : ST_INIT;
          end
        end
        else
          next_cnt = cnt + CNT_W'(1);
      end
      ST_SAMPLE:
      begin
        if (cnt == CNT_W'(SAMPLE_DLY_CYC - 1))
        begin
          next_flags = FLG_RESET;
          next_flags[FLG_SW] = 1'b1;
          next_flags[FLG_SHORT_HW] = 1'b1;
          next_flags[FLG_LONG_HW] = !rf_s2;
          if (rf_s2)
          begin
            next_p0_lat = p0_s2;
            next_state = ST_INIT;
          end
          else
            next_cnt = CNT_W'(SAMPLE_DLY_CYC);
        end
        else if (cnt == CNT_W'(SAMPLE_DLY_CYC))
        begin
          // Long reset: wait for the input to rise, the long flag stays set
          if (rf_s2)
          begin
            next_p0_lat = p0_s2;
            next_state = ST_INIT;
          end
        end
        else
          next_cnt = cnt + CNT_W'(1);
      end
      ST_WATCH:
      begin
        if (rf_s2)
          next_state = ST_INIT;
        // The first low samples are only the synchroniser catching up with the release
        else if (cnt == CNT_W'(SYNC_LAT_CYC + MIN_LOW_CYC - 1))
        begin
          next_src = SRC_HW;
          next_cnt = CNT_W'(MIN_LOW_CYC);
          next_state = ST_ENTRY;
        end
        else
          next_cnt = cnt + CNT_W'(1);
      end
      ST_INIT:
      begin
        if (!rf_s2)
        begin
          next_src = SRC_HW;
          next_cnt = CNT_W'(1);
          next_state = ST_ENTRY;
        end
        else if (soft_reset_instr)
        begin
          next_src = SRC_SW;
          next_cnt = '0;
          next_state = ST_ENTRY;
        end
        else if (wdt_overflow)
        begin
          next_src = SRC_WDT;
          next_cnt = '0;
          next_state = ST_BUSWAIT;
        end
        else if (end_of_init_instr)
        begin
          next_rout = 1'b1;
          next_initd = 1'b1;
          next_state = ST_RUN;
        end
      end
      default:
        next_state = ST_RUN;
    endcase
    if (rd)
    begin
      case (paddr)
        ADDR_CFG: next_rdata = {16'h0000, cfg};
        ADDR_FLAGS: next_rdata = {27'h0000000, flags};
        ADDR_P0: next_rdata = {16'h0000, p0_lat};
        ADDR_STATUS: next_rdata = {27'h0000000, initd, 1'b0, state};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_INIT;
      src <= SRC_HW;
      cnt <= '0;
      cfg <= CFG_RESET;
      flags <= FLG_RESET;
      p0_lat <= P0_RESET;
      initd <= 1'b0;
      pull <= 1'b0;
      rout <= 1'b0;
      pdu <= 1'b0;
      pdd <= 1'b0;
      abort_q <= 1'b0;
      areq <= 1'b0;
      rdata <= 32'h00000000;
    end
    else
    begin
      state <= next_state;
      src <= next_src;
      cnt <= next_cnt;
      cfg <= next_cfg;
      flags <= next_flags;
      p0_lat <= next_p0_lat;
      initd <= next_initd;
      pull <= next_pull;
      rout <= next_rout;
      pdu <= next_pdu;
      pdd <= next_pdd;
      abort_q <= next_abort_q;
      areq <= next_areq;
      rdata <= next_rdata;
    end
  end

  // Open-drain: drive low only while pulling
  assign reset_in_pin_o = 1'b0;
  assign reset_in_pin_oe = pull;
  assign reset_out_pin = rout;
  assign pd_pullup_en = pdu;
  assign pd_pulldown_en = pdd;
  assign bus_abort = abort_q;
  assign async_reset_req = areq;
  assign port_cfg = p0_lat;
  assign prdata = rdata;
  // Zero wait state slave; unmapped reads give zero, never an error
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  logic core_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      core_q <= 1'b1;
    else
      core_q <= (next_state != ST_RUN) && (next_state != ST_INIT);
  end
  assign core_reset = core_q;

  a_seq_pull_end: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_SEQ && cnt == CNT_W'(SEQ_LEN_CYC - 1)) |=> !reset_in_pin_oe)
    else $error("pull-down not released at sequence end");
  a_bidir_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_SEQ && cnt == CNT_W'(SEQ_LEN_CYC - 1)) |=> !cfg[CFG_BIDIR_BIT])
    else $error("bidir enable not cleared");
  a_rout_low: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_SEQ) |-> !reset_out_pin)
    else $error("reset out high during sequence");
  a_pd_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_SEQ && src != SRC_HW && !pd_s2) |=> !reset_in_pin_oe)
    else $error("pin driven with powerdown low");
  a_cfg_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (initd && state == ST_RUN) |=> $stable(cfg))
    else $error("config changed after init");
  a_pulldown: assert property (@(posedge clk) disable iff (!rst_n)
    (!rf_s2) |=> pd_pulldown_en)
    else $error("powerdown pull-down off");
  a_async_req: assert property (@(posedge clk) disable iff (!rst_n)
    (!rf_s2 && !pd_s2 && !sw_seq) |=> async_reset_req)
    else $error("async reset not requested");
  a_sw_sync: assert property (@(posedge clk) disable iff (!rst_n)
    (sw_seq && !async_reset_req) |=> !async_reset_req)
    else $error("software reset turned asynchronous");
  a_long_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_SAMPLE && cnt == CNT_W'(SAMPLE_DLY_CYC)) |=> flags[FLG_LONG_HW])
    else $error("long flag lost");
  a_wdt_abort: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_BUSWAIT && bus_cycle_active && bus_uses_ready && bus_waits_done
     && ready_n) |=> bus_abort && state == ST_ENTRY)
    else $error("bus cycle not aborted");
  a_sw_latch: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_SEQ && src != SRC_HW && cnt == CNT_W'(SEQ_LEN_CYC - 1))
    |=> port_cfg[7:2] == P0_FORCED)
    else $error("port bits not forced");
  c_sw: cover property (@(posedge clk) disable iff (!rst_n)
    state == ST_SEQ && src == SRC_SW);
  c_wdt_abort: cover property (@(posedge clk) disable iff (!rst_n) bus_abort);
  c_degen: cover property (@(posedge clk) disable iff (!rst_n)
    state == ST_WATCH ##1 state == ST_ENTRY);
  c_long: cover property (@(posedge clk) disable iff (!rst_n) flags[FLG_LONG_HW]);
endmodule : rstseq_top

// ---- test/rstseq_ext.sv ----
// Board side of the reset pin: pull-up, wired-low drivers and the slow input filter.
// Assumes the bench drives ext_low and the design drives the open-drain enable.
module rstseq_ext (
  // Clock
  input wire logic clk,
  // Pin drivers
  input wire logic reset_in_pin_oe,
  input wire logic ext_low,
  input wire logic [4:0] filter_dly,
  // Pin and filtered level
  output logic reset_in_pin,
  output logic filtered_reset_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] hist = 32'hffffffff;
  // Pull-up wins unless a party pulls low; the bench holds ext_low at least 2 cycles
  assign reset_in_pin = !(reset_in_pin_oe || ext_low);
  always @(posedge clk) hist <= {hist[30:0], reset_in_pin};
  // A slow filter keeps the input low well after release, as a real RC filter would
  assign filtered_reset_in = (filter_dly == 5'h00) ? reset_in_pin : hist[filter_dly - 5'h01];
endmodule : rstseq_ext

// ---- test/rstseq_top_bench.sv ----
// Bench for the reset sequencer: APB master, CPU event pulses, board-side reset model.
// Assumes core_reset stays high through each internal sequence.
module rstseq_top_bench import rstseq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [3:0] paddr = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, bus_abort, filtered_reset_in, reset_in_pin, reset_in_pin_oe;
  logic reset_out_pin, pd_pullup_en, pd_pulldown_en, core_reset, async_reset_req;
  logic soft_reset_instr = 1'h0;
  logic end_of_init_instr = 1'h0;
  logic wdt_overflow = 1'h0;
  logic bus_cycle_active = 1'h0;
  logic bus_uses_ready = 1'h0;
  logic bus_waits_done = 1'h0;
  logic ready_n = 1'h0;
  logic powerdown_reset_pin = 1'h1;
  logic ext_low = 1'h0;
  logic [4:0] filter_dly = 5'h00;
  logic [15:0] config_port_zero = 16'h0000;
  logic [15:0] port_cfg;
  logic oe_mid, pd_mid, out_mid, oe_late, aborted, pin_o;
  int errors = 0;
  int samples_checked = 0;
  int len;

  rstseq_top u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .soft_reset_instr, .end_of_init_instr, .wdt_overflow, .bus_cycle_active,
    .bus_uses_ready, .bus_waits_done, .ready_n, .bus_abort, .filtered_reset_in,
    .powerdown_reset_pin, .config_port_zero, .reset_in_pin_o(pin_o), .reset_in_pin_oe,
    .reset_out_pin, .pd_pullup_en, .pd_pulldown_en, .core_reset, .async_reset_req, .port_cfg);
  rstseq_ext u_ext (.clk, .reset_in_pin_oe, .ext_low, .filter_dly, .reset_in_pin,
    .filtered_reset_in);

  initial
  begin
    forever #4 clk = ~clk;
  end

  function automatic logic [10:0] port_exp(input logic [15:0] p);
    return {p[12:8], P0_FORCED};
  endfunction : port_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude

  // Zero-wait slave today, but the master still waits for pready
  task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: soft_reset_instr <= 1'h1;
      1: end_of_init_instr <= 1'h1;
      default: wdt_overflow <= 1'h1;
    endcase
    @(posedge clk);
    soft_reset_instr <= 1'h0;
    end_of_init_instr <= 1'h0;
    wdt_overflow <= 1'h0;
  endtask : fire

  // Measures the first sequence, samples pins inside it, then waits for a quiet spell
  task automatic run(input int drop_at);
    int i;
    i = 0;
    while (core_reset !== 1'h1 && i < 200)
    begin
      @(posedge clk);
      aborted |= bus_abort;
      i++;
    end
    len = 0;
    while (core_reset === 1'h1 && len < 3000)
    begin
      @(posedge clk);
      aborted |= bus_abort;
      len++;
      if (len == 4)
      begin
        oe_mid = reset_in_pin_oe;
        pd_mid = pd_pulldown_en;
        out_mid = reset_out_pin;
      end
      if (len == drop_at)
        powerdown_reset_pin <= 1'h0;
      if (len == drop_at + 8)
        oe_late = reset_in_pin_oe;
    end
    i = 0;
    while (i < 16)
    begin
      @(posedge clk);
      i = (core_reset === 1'h1) ? 0 : i + 1;
    end
  endtask : run

  initial
  begin
    repeat (12000) @(posedge clk);
    errors++;
    $display("test timeout");
    conclude();
  end

  initial
  begin
    void'($urandom(32'hf931));
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    check(32'(reset_out_pin), 32'h0, "out after reset");
    apb(1'h0, ADDR_FLAGS, 32'h0);
    check(rd, 32'(FLG_RESET), "flags reset");
    apb(1'h0, 4'h2, 32'h0);
    check(rd, 32'h0, "unmapped read");
    check(32'(pslverr), 32'h0, "no error");
    apb(1'h1, ADDR_CFG, 32'h18);
    apb(1'h0, ADDR_CFG, 32'h0);
    check(rd, 32'h18, "cfg write");
    fire(1);
    @(posedge clk);
    check(32'(reset_out_pin), 32'h1, "out after init");
    apb(1'h1, ADDR_CFG, 32'h0);
    apb(1'h0, ADDR_CFG, 32'h0);
    check(rd, 32'h18, "cfg locked");
    $display("test init done");
    config_port_zero <= 16'($urandom);
    fire(0);
    run(0);
    check(32'(len >= SEQ_LEN_CYC && len <= SEQ_LEN_CYC + ENTRY_CYC + 4), 32'h1, "len");
    check(32'(oe_mid), 32'h1, "bidir drive");
    check(32'(pd_mid), 32'h1, "pd pulldown");
    check(32'(out_mid), 32'h0, "out in seq");
    check(32'(reset_in_pin_oe), 32'h0, "drive released");
    check(32'(pin_o), 32'h0, "open-drain level");
    check(32'(port_cfg[12:2]), 32'(port_exp(config_port_zero)), "port latch");
    check(32'(pd_pullup_en), 32'h1, "pd pullup");
    apb(1'h0, ADDR_FLAGS, 32'h0);
    check(32'(rd[FLG_SW]), 32'h1, "sw flag");
    apb(1'h0, ADDR_CFG, 32'h0);
    check(32'(rd[CFG_BIDIR_BIT]), 32'h0, "bidir cleared");
    $display("test soft done");
    apb(1'h1, ADDR_CFG, 32'h8);
    config_port_zero <= 16'($urandom);
    powerdown_reset_pin <= 1'h0;
    bus_cycle_active <= 1'h1;
    bus_uses_ready <= 1'h1;
    bus_waits_done <= 1'h1;
    ready_n <= 1'h1;
    aborted = 1'h0;
    fire(2);
    run(0);
    check(32'(aborted), 32'h1, "abort");
    check(32'(oe_mid), 32'h0, "wdt no drive");
    check(32'(port_cfg[12:2]), 32'(port_exp(config_port_zero)), "wdt latch");
    apb(1'h0, ADDR_FLAGS, 32'h0);
    check(32'(rd[FLG_WDT]), 32'h1, "wdt flag");
    $display("test wdt abort done");
    apb(1'h1, ADDR_CFG, 32'h8);
    powerdown_reset_pin <= 1'h1;
    bus_waits_done <= 1'h0;
    ready_n <= 1'h0;
    filter_dly <= 5'd20 + 5'($urandom % 10);
    aborted = 1'h0;
    fire(2);
    repeat (20) @(posedge clk);
    check(32'(core_reset), 32'h1, "bus pending");
    apb(1'h0, ADDR_STATUS, 32'h0);
    check(32'(rd[2:0]), 32'(ST_BUSWAIT), "still waiting on bus");
    bus_waits_done <= 1'h1;
    run(0);
    bus_cycle_active <= 1'h0;
    filter_dly <= 5'h00;
    check(32'(aborted), 32'h0, "no abort");
    apb(1'h0, ADDR_FLAGS, 32'h0);
    check(32'(rd[FLG_SHORT_HW]), 32'h1, "hw after wdt");
    check(32'(rd[FLG_WDT]), 32'h0, "wdt masked");
    $display("test wdt slow filter done");
    apb(1'h1, ADDR_CFG, 32'h8);
    fire(0);
    run(50);
    check(32'(oe_mid), 32'h1, "drive before drop");
    check(32'(oe_late), 32'h0, "drive after drop");
    check(32'(len >= SEQ_LEN_CYC), 32'h1, "seq completes");
    check(32'(async_reset_req), 32'h0, "soft stays sync");
    powerdown_reset_pin <= 1'h1;
    $display("test powerdown drop done");
    ext_low <= 1'h1;
    fork
      run(0);
      begin
        // Release just after the 8-unit sample point so the long outcome is clear
        repeat (ENTRY_CYC + SEQ_LEN_CYC + SAMPLE_DLY_CYC + 12) @(posedge clk);
        ext_low <= 1'h0;
      end
    join
    check(32'(pd_mid), 32'h1, "hw pulldown");
    apb(1'h0, ADDR_FLAGS, 32'h0);
    check(32'(rd[FLG_LONG_HW]), 32'h1, "long flag");
    $display("test long hw done");
    powerdown_reset_pin <= 1'h0;
    ext_low <= 1'h1;
    repeat (6) @(posedge clk);
    check(32'(async_reset_req), 32'h1, "async req");
    ext_low <= 1'h0;
    $display("test async done");
    conclude();
  end
endmodule : rstseq_top_bench
